// ---- rtl/irq_controller_cfg.svh ----
`ifndef IRQ_CONTROLLER_CFG_SVH
`define IRQ_CONTROLLER_CFG_SVH
`define NUM_SRC          16
`define SRC_IDX_W        4
`define PRIO_W           2
`define VAB_W            21
`define VBASE_W          13
`define VOFS_W           8
`define LAST_W           16
`define FAST_HIGH_W      5
`define ADDR_W           8
`define DATA_W           16
`define CLASS_MASK_RST   16'hFF00
`define PEND_PER_REG     16
`define PRIO_PER_REG     8
`define OFS_PEND0        8'h00
`define OFS_PRIO0        8'h04
`define OFS_PRIO1        8'h05
`define OFS_VBASE        8'h08
`define OFS_PLEVEL       8'h09
`define OFS_LASTVEC      8'h0A
`define OFS_FAST0_SEL    8'h0B
`define OFS_FAST0_LOW    8'h0C
`define OFS_FAST0_HIGH   8'h0D
`define OFS_FAST1_SEL    8'h0E
`define OFS_FAST1_LOW    8'h0F
`define OFS_FAST1_HIGH   8'h10
`define OFS_FAST_CTL     8'h11
`define OFS_IRQ_STATUS   8'h12
`define OFS_IRQ_MASK     8'h13
`define VOFS_FIRST_SRC   8'h10
`define EV_TAKEN_BIT     0
`define EV_FAST_BIT      1
`define EV_NEST_BIT      2
`define EV_W             3
`endif

// ---- rtl/irq_controller_pkg.sv ----
package irq_controller_pkg;
  typedef enum logic [1:0] {
    TAKE_NORMAL,
    TAKE_FAST0,
    TAKE_FAST1
  } take_kind_t;
endpackage

// ---- rtl/prio_select.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "irq_controller_cfg.svh"
// picks the highest-level eligible source; lowest index wins a tie
module prio_select (
  input  wire logic [`NUM_SRC-1:0]          eligible,
  input  wire logic [2*`NUM_SRC-1:0]        levels,
  output logic                              found,
  output logic [`SRC_IDX_W-1:0]             winner,
  output logic [1:0]                        win_level
);
  always_comb begin
    found     = 1'b0;
    winner    = '0;
    win_level = 2'h0;
    for (int i = `NUM_SRC - 1; i >= 0; i--) begin
      if (eligible[i] && (!found || levels[2*i +: 2] >= win_level)) begin
        found     = 1'b1;
        winner    = i[`SRC_IDX_W-1:0];
        win_level = levels[2*i +: 2];
      end
    end
  end
endmodule
`default_nettype wire

// ---- rtl/irq_controller.sv ----
// What this block does
// - priority zero disables, one to three enable
// - class maps numbers to levels 1-3 or 0-2
// - priority field keeps two low bits only
// - vector is base upper 13 bits plus offset
// - fast zero jumps to its programmed address
// - fast one jumps to its programmed address
// - higher priority request nests over current one
// - permitted level readable, gates new requests
// - pending set on request, cleared on entry
// - last vector records vector number taken
// - fast take records low jump address bits
// - last vector kept after service ends
// - pending bits packed by interrupt number
// - priority fields packed by interrupt number
`timescale 1ns/1ps
`default_nettype none
`include "irq_controller_cfg.svh"
module irq_controller
  import irq_controller_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic [`NUM_SRC-1:0]    irq_req,
  input  wire logic                   core_ack,
  input  wire logic                   core_rti,
  output logic                        core_irq,
  output logic [`VAB_W-1:0]           irq_vector_address,
  output logic [1:0]                  core_level,
  input  wire logic [`ADDR_W-1:0]     reg_addr,
  input  wire logic [`DATA_W-1:0]     reg_wdata,
  input  wire logic                   reg_write,
  input  wire logic                   reg_read,
  output logic [`DATA_W-1:0]          reg_rdata,
  output logic                        irq_out
);
  logic [`NUM_SRC-1:0]     req_s1_reg;
  logic [`NUM_SRC-1:0]     req_s2_reg;
  logic [`NUM_SRC-1:0]     req_prev_reg;
  logic [`NUM_SRC-1:0]     pending_reg;
  logic [2*`NUM_SRC-1:0]   prio_reg;
  logic [`NUM_SRC-1:0]     class_reg;
  logic [`VBASE_W-1:0]     vector_base_reg;
  logic [1:0]              plevel_reg;
  logic [1:0]              plevel_stack_reg [4];
  logic [2:0]              depth_reg;
  logic [`LAST_W-1:0]      last_vec_reg;
  logic [`SRC_IDX_W-1:0]   fast0_sel_reg;
  logic [`SRC_IDX_W-1:0]   fast1_sel_reg;
  logic [1:0]              fast_en_reg;
  logic [15:0]             fast0_addr_low;
  logic [`FAST_HIGH_W-1:0] fast0_addr_high;
  logic [15:0]             fast1_addr_low;
  logic [`FAST_HIGH_W-1:0] fast1_addr_high;
  logic [`EV_W-1:0]        status_reg;
  logic [`EV_W-1:0]        mask_reg;
  logic [`EV_W-1:0]        ev_next;
  logic [`DATA_W-1:0]      rdata_next;
  logic [2*`NUM_SRC-1:0]   levels;
  logic [`NUM_SRC-1:0]     eligible;
  logic                    found;
  logic [`SRC_IDX_W-1:0]   winner;
  logic [1:0]              win_level;
  logic                    core_irq_reg;
  logic [`SRC_IDX_W-1:0]   pres_src_reg;
  logic [1:0]              pres_level_reg;
  logic [`VAB_W-1:0]       vab_reg;
  take_kind_t              pres_kind;
  logic                    take;
  logic                    outranked;

  // level of one source from its number and class
  function automatic logic [1:0] num_to_level(input logic [1:0] num, input logic cls);
    if (cls)
      num_to_level = num - 2'h1;
    else
      num_to_level = num;
  endfunction

  // vector offset of a source number
  function automatic logic [`VOFS_W-1:0] src_offset(input logic [`SRC_IDX_W-1:0] s);
    src_offset = `VOFS_FIRST_SRC + {4'h0, s};
  endfunction

  // two-flop sync, then edge detect on the second stage
  always_ff @(posedge clk) begin
    if (reset) begin
      req_s1_reg   <= '0;
      req_s2_reg   <= '0;
      req_prev_reg <= '0;
    end else begin
      req_s1_reg   <= irq_req;
      req_s2_reg   <= req_s1_reg;
      req_prev_reg <= req_s2_reg;
    end
  end

  always_comb begin
    levels   = '0;
    eligible = '0;
    for (int i = 0; i < `NUM_SRC; i++) begin
      levels[2*i +: 2] = num_to_level(prio_reg[2*i +: 2], class_reg[i]);
      eligible[i] = pending_reg[i] && (prio_reg[2*i +: 2] != 2'h0)
                    && (depth_reg == 3'h0 || levels[2*i +: 2] >= plevel_reg);
    end
  end

  prio_select u_sel (
    .eligible  (eligible),
    .levels    (levels),
    .found     (found),
    .winner    (winner),
    .win_level (win_level)
  );

  assign take = core_irq_reg && core_ack;

  always_comb begin
    if (fast_en_reg[0] && pres_src_reg == fast0_sel_reg)
      pres_kind = TAKE_FAST0;
    else if (fast_en_reg[1] && pres_src_reg == fast1_sel_reg)
      pres_kind = TAKE_FAST1;
    else
      pres_kind = TAKE_NORMAL;
  end

  // presentation to the core; a better request replaces a waiting one
  always_ff @(posedge clk) begin
    if (reset) begin
      core_irq_reg   <= 1'b0;
      pres_src_reg   <= '0;
      pres_level_reg <= 2'h0;
    end else if (take) begin
      core_irq_reg <= 1'b0;
    end else begin
      core_irq_reg   <= found && depth_reg != 3'h4;
      pres_src_reg   <= winner;
      pres_level_reg <= win_level;
    end
  end

  always_comb begin
    case (pres_kind)
      TAKE_FAST0: vab_reg = {fast0_addr_high, fast0_addr_low};
      TAKE_FAST1: vab_reg = {fast1_addr_high, fast1_addr_low};
      default:    vab_reg = {vector_base_reg, src_offset(pres_src_reg)};
    endcase
  end

  assign core_irq           = core_irq_reg;
  assign irq_vector_address = vab_reg;
  assign core_level         = pres_level_reg;

  // pending: a new edge wins over the clear on entry
  always_ff @(posedge clk) begin
    if (reset) begin
      pending_reg <= '0;
    end else begin
      for (int i = 0; i < `NUM_SRC; i++) begin
        if (req_s2_reg[i] && !req_prev_reg[i])
          pending_reg[i] <= 1'b1;
        else if (take && pres_src_reg == i[`SRC_IDX_W-1:0])
          pending_reg[i] <= 1'b0;
      end
    end
  end

  // nesting: entry raises the permitted level one above the taken one, holding at 3 when level 3 is taken
  always_ff @(posedge clk) begin
    if (reset) begin
      depth_reg  <= 3'h0;
      plevel_reg <= 2'h0;
      for (int i = 0; i < 4; i++)
        plevel_stack_reg[i] <= 2'h0;
    end else if (take) begin
      plevel_stack_reg[depth_reg[1:0]] <= plevel_reg;
      depth_reg  <= depth_reg + 3'h1;
      plevel_reg <= (pres_level_reg == 2'h3) ? 2'h3 : pres_level_reg + 2'h1;
    end else if (core_rti && depth_reg != 3'h0) begin
      depth_reg  <= depth_reg - 3'h1;
      plevel_reg <= plevel_stack_reg[depth_reg[1:0] - 2'h1];
    end
  end

  // last vector: only a take updates it, so it survives service end
  always_ff @(posedge clk) begin
    if (reset)
      last_vec_reg <= '0;
    else if (take) begin
      if (pres_kind == TAKE_NORMAL)
        last_vec_reg <= {8'h00, src_offset(pres_src_reg)};
      else
        last_vec_reg <= vab_reg[`LAST_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prio_reg        <= '0;
      class_reg       <= `CLASS_MASK_RST;
      vector_base_reg <= '0;
      fast0_sel_reg   <= '0;
      fast1_sel_reg   <= '0;
      fast_en_reg     <= 2'h0;
      fast0_addr_low  <= '0;
      fast0_addr_high <= '0;
      fast1_addr_low  <= '0;
      fast1_addr_high <= '0;
      mask_reg        <= '0;
    end else if (reg_write) begin
      case (reg_addr)
        `OFS_PRIO0:      prio_reg[15:0]  <= reg_wdata;
        `OFS_PRIO1:      prio_reg[31:16] <= reg_wdata;
        `OFS_VBASE:      vector_base_reg <= reg_wdata[`VBASE_W-1:0];
        `OFS_FAST0_SEL:  fast0_sel_reg   <= reg_wdata[`SRC_IDX_W-1:0];
        `OFS_FAST0_LOW:  fast0_addr_low  <= reg_wdata;
        `OFS_FAST0_HIGH: fast0_addr_high <= reg_wdata[`FAST_HIGH_W-1:0];
        `OFS_FAST1_SEL:  fast1_sel_reg   <= reg_wdata[`SRC_IDX_W-1:0];
        `OFS_FAST1_LOW:  fast1_addr_low  <= reg_wdata;
        `OFS_FAST1_HIGH: fast1_addr_high <= reg_wdata[`FAST_HIGH_W-1:0];
        `OFS_FAST_CTL: begin
          fast_en_reg <= reg_wdata[1:0];
          class_reg   <= class_reg;
        end
        `OFS_IRQ_MASK:   mask_reg        <= reg_wdata[`EV_W-1:0];
        default: ;
      endcase
    end
  end

  // events for the local interrupt line
  always_comb begin
    ev_next = '0;
    ev_next[`EV_TAKEN_BIT] = take;
    ev_next[`EV_FAST_BIT]  = take && pres_kind != TAKE_NORMAL;
    ev_next[`EV_NEST_BIT]  = take && depth_reg != 3'h0;
  end

  // set wins over write-one-to-clear
  always_ff @(posedge clk) begin
    if (reset)
      status_reg <= '0;
    else if (reg_write && reg_addr == `OFS_IRQ_STATUS)
      status_reg <= (status_reg & ~reg_wdata[`EV_W-1:0]) | ev_next;
    else
      status_reg <= status_reg | ev_next;
  end

  assign irq_out = |(status_reg & mask_reg);

  always_comb begin
    rdata_next = '0;
    case (reg_addr)
      `OFS_PEND0:      rdata_next = pending_reg;
      `OFS_PRIO0:      rdata_next = prio_reg[15:0];
      `OFS_PRIO1:      rdata_next = prio_reg[31:16];
      `OFS_VBASE:      rdata_next[`VBASE_W-1:0] = vector_base_reg;
      `OFS_PLEVEL:     rdata_next[1:0] = plevel_reg;
      `OFS_LASTVEC:    rdata_next = last_vec_reg;
      `OFS_FAST0_SEL:  rdata_next[`SRC_IDX_W-1:0] = fast0_sel_reg;
      `OFS_FAST0_LOW:  rdata_next = fast0_addr_low;
      `OFS_FAST0_HIGH: rdata_next[`FAST_HIGH_W-1:0] = fast0_addr_high;
      `OFS_FAST1_SEL:  rdata_next[`SRC_IDX_W-1:0] = fast1_sel_reg;
      `OFS_FAST1_LOW:  rdata_next = fast1_addr_low;
      `OFS_FAST1_HIGH: rdata_next[`FAST_HIGH_W-1:0] = fast1_addr_high;
      `OFS_FAST_CTL:   rdata_next[1:0] = fast_en_reg;
      `OFS_IRQ_STATUS: rdata_next[`EV_W-1:0] = status_reg;
      `OFS_IRQ_MASK:   rdata_next[`EV_W-1:0] = mask_reg;
      default:         rdata_next = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset)
      reg_rdata <= '0;
    else if (reg_read)
      reg_rdata <= rdata_next;
    else
      reg_rdata <= '0;
  end

  sequence seq_taken;
    take;
  endsequence

  chk_disabled_never_won: assert property (@(posedge clk) disable iff (reset)
    core_irq |-> prio_reg[2*pres_src_reg +: 2] != 2'h0 || $past(prio_reg) != prio_reg)
    else $error("disabled source presented");
  chk_pending_clears: assert property (@(posedge clk) disable iff (reset)
    seq_taken ##0 !(req_s2_reg[pres_src_reg] && !req_prev_reg[pres_src_reg])
    |=> !pending_reg[$past(pres_src_reg)])
    else $error("pending not cleared on entry");
  chk_last_vec_hold: assert property (@(posedge clk) disable iff (reset)
    !take |=> $stable(last_vec_reg))
    else $error("last vector changed without take");
  chk_last_vec_normal: assert property (@(posedge clk) disable iff (reset)
    take && pres_kind == TAKE_NORMAL |=> last_vec_reg[`VOFS_W-1:0] == $past(vab_reg[`VOFS_W-1:0]))
    else $error("last vector not the vector number");
  chk_fast0_addr: assert property (@(posedge clk) disable iff (reset)
    core_irq && fast_en_reg[0] && pres_src_reg == fast0_sel_reg
    |-> irq_vector_address == {fast0_addr_high, fast0_addr_low})
    else $error("fast zero address wrong");
  chk_fast1_addr: assert property (@(posedge clk) disable iff (reset)
    core_irq && fast_en_reg[1] && pres_src_reg == fast1_sel_reg
    && !(fast_en_reg[0] && pres_src_reg == fast0_sel_reg)
    |-> irq_vector_address == {fast1_addr_high, fast1_addr_low})
    else $error("fast one address wrong");
  chk_vector_base: assert property (@(posedge clk) disable iff (reset)
    core_irq && pres_kind == TAKE_NORMAL
    |-> irq_vector_address == {vector_base_reg, `VOFS_FIRST_SRC + {4'h0, pres_src_reg}})
    else $error("vector base bits wrong");
  chk_nest_level: assert property (@(posedge clk) disable iff (reset)
    take && pres_level_reg != 2'h3 |=> plevel_reg == $past(pres_level_reg) + 2'h1)
    else $error("permitted level not raised");
  chk_irq_out: assert property (@(posedge clk) disable iff (reset)
    take |=> ##1 (!mask_reg[`EV_TAKEN_BIT] || $past(reg_write) || irq_out))
    else $error("interrupt line not raised");

  // reference ordering for the selector check, kept apart from the selector itself
  always_comb begin
    outranked = 1'b0;
    for (int i = 0; i < `NUM_SRC; i++) begin
      if (eligible[i] && (levels[2*i +: 2] > win_level
          || (levels[2*i +: 2] == win_level && i < int'(winner))))
        outranked = 1'b1;
    end
  end

  chk_prio_reset: assert property (@(posedge clk)
    $fell(reset) |-> prio_reg == '0)
    else $error("priority not cleared by reset");
  chk_prio_low_write: assert property (@(posedge clk) disable iff (reset)
    reg_write && reg_addr == `OFS_PRIO0 |=> prio_reg[15:0] == $past(reg_wdata))
    else $error("low priority word not stored");
  chk_prio_high_write: assert property (@(posedge clk) disable iff (reset)
    reg_write && reg_addr == `OFS_PRIO1 |=> prio_reg[31:16] == $past(reg_wdata))
    else $error("high priority word not stored");
  chk_class_map: assert property (@(posedge clk) disable iff (reset)
    !take && found
    |=> core_level == $past(prio_reg[2*winner +: 2]) - ($past(class_reg[winner]) ? 2'h1 : 2'h0))
    else $error("presented level does not follow class");
  chk_permitted_gate: assert property (@(posedge clk) disable iff (reset)
    depth_reg != 3'h0 && !take |=> !core_irq || core_level >= $past(plevel_reg))
    else $error("request below permitted level presented");
  chk_select_order: assert property (@(posedge clk) disable iff (reset)
    found |-> eligible[winner] && !outranked)
    else $error("selector skipped a better request");
  chk_pending_set: assert property (@(posedge clk) disable iff (reset)
    (req_s2_reg & ~req_prev_reg) != '0
    |=> (pending_reg & $past(req_s2_reg & ~req_prev_reg)) == $past(req_s2_reg & ~req_prev_reg))
    else $error("pending not set by request");
  chk_fast_last: assert property (@(posedge clk) disable iff (reset)
    take && pres_kind != TAKE_NORMAL
    |=> last_vec_reg == $past(pres_kind == TAKE_FAST0 ? fast0_addr_low : fast1_addr_low))
    else $error("last vector not the fast address bits");
endmodule
`default_nettype wire

// ---- bench/core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// stand-in for the core: takes a presented request after a set delay
module core_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       core_irq,
  input  wire logic       auto_ack,
  input  wire logic [3:0] ack_delay,
  input  wire logic       rti_go,
  output logic            core_ack,
  output logic            core_rti
);
  logic [3:0] wait_cnt;
  // count restarts after each ack, so a lingering core_irq is not taken twice
  always_ff @(posedge clk) begin
    if (reset || core_ack || !core_irq || !auto_ack) begin
      core_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (wait_cnt >= ack_delay) begin
      core_ack <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    core_rti <= !reset && rti_go;
  end
endmodule
`default_nettype wire

// ---- bench/priority_interrupt_controller_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module priority_interrupt_controller_test;
  logic [20:0] irq_vector_address;
  logic [15:0] irq_req;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [7:0]  reg_addr;
  logic [3:0]  ack_delay;
  logic [1:0]  core_level;
  logic        clk;
  logic        reset;
  logic        core_ack;
  logic        core_rti;
  logic        core_irq;
  logic        reg_write;
  logic        reg_read;
  logic        irq_out;
  logic        auto_ack;
  logic        rti_go;
  int          n_mismatch;
  int          n_compared;

  irq_controller i_dut (.clk(clk), .reset(reset), .irq_req(irq_req), .core_ack(core_ack),
    .core_rti(core_rti), .core_irq(core_irq), .irq_vector_address(irq_vector_address),
    .core_level(core_level), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq_out(irq_out));
  core_model i_core (.clk(clk), .reset(reset), .core_irq(core_irq), .auto_ack(auto_ack),
    .ack_delay(ack_delay), .rti_go(rti_go), .core_ack(core_ack), .core_rti(core_rti));

  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk(21'(reg_rdata & m), 21'(e));
    @(posedge clk);
  endtask
  task automatic wirq(input logic v);
    int i;
    #1;
    for (i = 0; i < 40 && core_irq !== v; i++)
      @(posedge clk) #1;
    chk(21'(core_irq), 21'(v));
  endtask
  // requests are edges after a sync, so hold three cycles then drop
  task automatic req(input logic [15:0] m);
    irq_req <= irq_req | m;
    repeat (3) @(posedge clk);
    irq_req <= irq_req & ~m;
  endtask
  task automatic rti();
    rti_go <= 1'b1;
    @(posedge clk);
    rti_go <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic t_reset();
    rc(8'h04, 16'hFFFF, 16'h0000);
    rc(8'h05, 16'hFFFF, 16'h0000);
    rc(8'h7F, 16'hFFFF, 16'h0000);
    req(16'h0400);
    repeat (8) @(posedge clk);
    #1 chk(21'(core_irq), 21'h0);
    $display("reset and disabled source done");
  endtask
  task automatic t_normal(input int s, input logic [1:0] pn, input logic [1:0] lv);
    logic [15:0] b;
    b = 16'h0001 << s;
    ack_delay <= 4'hC;
    wr(s < 8 ? 8'h04 : 8'h05, 16'(pn) << (2 * (s % 8)));
    wr(8'h08, 16'h0155);
    req(b);
    wirq(1'b1);
    chk(irq_vector_address, {13'h0155, 8'h10 + 8'(s)});
    chk(21'(core_level), 21'(lv));
    rc(8'h00, b, b);
    wirq(1'b0);
    rc(8'h00, b, 16'h0000);
    rti();
    rc(8'h0A, 16'hFFFF, 16'h0010 + 16'(s));
    wr(s < 8 ? 8'h04 : 8'h05, 16'h0000);
    $display("normal take of source %0d done", s);
  endtask
  task automatic t_irq();
    rc(8'h12, 16'hFFFF, 16'h0001);
    #1 chk(21'(irq_out), 21'h0);
    wr(8'h13, 16'h0001);
    repeat (2) @(posedge clk);
    #1 chk(21'(irq_out), 21'h1);
    wr(8'h12, 16'h0001);
    repeat (2) @(posedge clk);
    #1 chk(21'(irq_out), 21'h0);
    rc(8'h12, 16'hFFFF, 16'h0000);
    $display("status, mask and clear done");
  endtask
  task automatic t_fast(input int k, input int s);
    logic [7:0]  o;
    logic [15:0] lo;
    o = k ? 8'h0E : 8'h0B;
    lo = 16'hC3A0 + 16'(k);
    wr(o, 16'(s));
    wr(o + 8'h01, lo);
    wr(o + 8'h02, 16'h0015);
    wr(8'h11, 16'h0001 << k);
    wr(8'h04, 16'h0002 << (2 * s));
    req(16'h0001 << s);
    wirq(1'b1);
    chk(irq_vector_address, {5'h15, lo});
    wirq(1'b0);
    rti();
    rc(8'h0A, 16'hFFFF, lo);
    wr(8'h11, 16'h0000);
    wr(8'h04, 16'h0000);
    $display("fast channel %0d done", k);
  endtask
  task automatic t_nest();
    ack_delay <= 4'h2;
    wr(8'h04, 16'h3600);
    req(16'h0010);
    wirq(1'b1);
    wirq(1'b0);
    rc(8'h09, 16'h0003, 16'h0003);
    req(16'h0020);
    repeat (8) @(posedge clk);
    #1 chk(21'(core_irq), 21'h0);
    req(16'h0040);
    wirq(1'b1);
    chk(21'(core_level), 21'h3);
    wirq(1'b0);
    rc(8'h12, 16'h0004, 16'h0004);
    rti();
    #1 chk(21'(core_irq), 21'h0);
    rti();
    wirq(1'b1);
    chk(irq_vector_address, {13'h0155, 8'h15});
    wirq(1'b0);
    rti();
    wr(8'h04, 16'h0000);
    $display("nesting done");
  endtask
  task automatic t_tie();
    ack_delay <= 4'hA;
    wr(8'h04, 16'h0028);
    req(16'h0006);
    wirq(1'b1);
    chk(irq_vector_address, {13'h0155, 8'h11});
    wirq(1'b0);
    rti();
    wirq(1'b1);
    chk(irq_vector_address, {13'h0155, 8'h12});
    wirq(1'b0);
    rti();
    $display("tie order done");
  endtask
  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    reset = 1'b1;
    irq_req = 16'h0000;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    auto_ack = 1'b1;
    ack_delay = 4'h2;
    rti_go = 1'b0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_normal(2, 2'h3, 2'h3);
    t_irq();
    t_normal(9, 2'h1, 2'h0);
    t_normal(1, 2'h1, 2'h1);
    t_normal(15, 2'h3, 2'h2);
    t_fast(0, 3);
    t_fast(1, 7);
    t_nest();
    t_tie();
    final_report();
  end
  initial begin
    #40000;
    n_mismatch++;
    final_report();
  end
endmodule
`default_nettype wire
